// ---- logic/sbd_defines.vh ----
// Purpose: shared constants for the subtract-with-borrow / decrement-skip datapath
// Assumes: included by bare name
// Notes:   definitions only
`ifndef SBD_DEFINES_VH
`define SBD_DEFINES_VH

// ----------------------------------------------------------------------
// operation select
// ----------------------------------------------------------------------
`define SBD_OP_SUB        1'h0
`define SBD_OP_DEC        1'h1

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define SBD_DATA_RST      8'h00
`define SBD_ADDR_RST      8'h00
`define SBD_FLAG_RST      1'h0
`define SBD_DEC_STEP      8'h01
`define SBD_ZERO          8'h00

`endif

// ---- logic/sbd_sub_flags.v ----
// Purpose: combinational subtract with borrow and its six status flags
// Assumes: operands stable in the cycle they are read
// Notes:   pure logic, no state
`timescale 1ns/1ps
`default_nettype none
`include "sbd_defines.vh"

module sbd_sub_flags #(
   parameter W = 8
) (
   input  wire [W-1:0] i_acc,
   input  wire [W-1:0] i_mem,
   input  wire         i_borrow_inverse,
   input  wire         i_extended_null,
   output wire [W-1:0] o_result,
   output wire         o_signed_range,
   output wire         o_result_null,
   output wire         o_nibble_borrow,
   output wire         o_borrow_inverse,
   output wire         o_signed_result,
   output wire         o_extended_null
);

   // ----------------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------------
   wire [W:0] full_diff;
   wire [4:0] nib_diff;
   wire       borrow_in;

   assign borrow_in = ~i_borrow_inverse;
   assign full_diff = {1'b0, i_acc} - {1'b0, i_mem} - {{W{1'b0}}, borrow_in};
   assign nib_diff  = {1'b0, i_acc[3:0]} - {1'b0, i_mem[3:0]} - {4'h0, borrow_in};
   assign o_result  = full_diff[W-1:0];

   // ----------------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------------
   assign o_borrow_inverse = ~full_diff[W];
   assign o_nibble_borrow  = ~nib_diff[4];
   assign o_signed_range   = (i_acc[W-1] ^ i_mem[W-1]) & (i_acc[W-1] ^ full_diff[W-1]);
   assign o_result_null    = (full_diff[W-1:0] == {W{1'b0}});
   assign o_signed_result  = o_signed_range ^ full_diff[W-1];
   assign o_extended_null  = o_result_null & i_extended_null;

endmodule // sbd_sub_flags
`default_nettype wire

// ---- logic/subtract_borrow_decrement_skip.v ----
// Purpose: execution datapath for subtract-with-borrow-to-memory and decrement-skip-if-null
// Assumes: operand and flags are valid on the same clock as I_OP_VALID
// Notes:   one request at a time; requests while busy are ignored
`timescale 1ns/1ps
`default_nettype none
`include "sbd_defines.vh"

module subtract_borrow_decrement_skip #(
   parameter W = 8
) (
   input  wire         I_CLOCK,
   input  wire         I_SYS_RST,
   input  wire         I_OP_VALID,
   input  wire         I_OP_SEL,
   input  wire [7:0]   I_ADDR,
   input  wire [W-1:0] I_MEM_RDATA,
   input  wire [W-1:0] I_WORKING_REGISTER,
   input  wire         I_BORROW_INVERSE,
   input  wire         I_EXTENDED_NULL,
   output wire         O_BUSY,
   output wire         O_DONE,
   output reg          O_MEM_WE,
   output reg  [7:0]   O_MEM_WADDR,
   output reg  [W-1:0] O_MEM_WDATA,
   output reg          O_FLAGS_WE,
   output reg          O_SIGNED_RANGE,
   output reg          O_RESULT_NULL,
   output reg          O_NIBBLE_BORROW,
   output reg          O_BORROW_INVERSE,
   output reg          O_SIGNED_RESULT,
   output reg          O_EXTENDED_NULL,
   output reg          O_SKIP_NEXT,
   output reg          O_DUMMY_CYCLE
);

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_DUMMY = 3'h4;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg       dec_null_q;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   function is_sub;
      input op_sel;
      begin
         is_sub = (op_sel == `SBD_OP_SUB);
      end
   endfunction

   // ----------------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------------
   wire [W-1:0] sub_result;
   wire         f_range;
   wire         f_null;
   wire         f_nibble;
   wire         f_borrow;
   wire         f_sign;
   wire         f_ext;
   wire [W-1:0] dec_result;
   wire         accept;
   wire         sub_sel;
   wire [W-1:0] wdata_d;
   wire         dec_null_d;
   wire         skip_d;

   sbd_sub_flags #(
      .W (W)
   ) u_sub (
      .i_acc            (I_WORKING_REGISTER),
      .i_mem            (I_MEM_RDATA),
      .i_borrow_inverse (I_BORROW_INVERSE),
      .i_extended_null  (I_EXTENDED_NULL),
      .o_result         (sub_result),
      .o_signed_range   (f_range),
      .o_result_null    (f_null),
      .o_nibble_borrow  (f_nibble),
      .o_borrow_inverse (f_borrow),
      .o_signed_result  (f_sign),
      .o_extended_null  (f_ext)
   );

   assign dec_result = I_MEM_RDATA - `SBD_DEC_STEP;
   assign accept     = I_OP_VALID & state_q[0];
   assign O_BUSY     = ~state_q[0];
   assign O_DONE     = (state_q[1] & ~dec_null_q) | state_q[2];
   assign sub_sel    = is_sub(I_OP_SEL);
   assign wdata_d    = sub_sel ? sub_result : dec_result;
   assign dec_null_d = (dec_result == `SBD_ZERO);
   assign skip_d     = state_q[1] & dec_null_q;

   // ----------------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (dec_null_q) begin
               state_d = ST_DUMMY;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_DUMMY: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         state_q    <= ST_IDLE;
         dec_null_q <= `SBD_FLAG_RST;
      end else begin
         state_q <= state_d;
         if (accept) begin
            dec_null_q <= sub_sel ? `SBD_FLAG_RST : dec_null_d;
         end else if (state_q[2]) begin
            dec_null_q <= `SBD_FLAG_RST;
         end
      end
   end

   // ----------------------------------------------------------------------
   // skip signalling
   // ----------------------------------------------------------------------
   always @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_SKIP_NEXT   <= `SBD_FLAG_RST;
         O_DUMMY_CYCLE <= `SBD_FLAG_RST;
      end else begin
         O_SKIP_NEXT   <= skip_d;
         O_DUMMY_CYCLE <= skip_d;
      end
   end

   // ----------------------------------------------------------------------
   // memory write port
   // ----------------------------------------------------------------------
   always @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_MEM_WE    <= `SBD_FLAG_RST;
         O_MEM_WADDR <= `SBD_ADDR_RST;
         O_MEM_WDATA <= `SBD_DATA_RST;
      end else begin
         O_MEM_WE <= accept;
         if (accept) begin
            O_MEM_WADDR <= I_ADDR;
            O_MEM_WDATA <= wdata_d;
         end
      end
   end

   // ----------------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------------
   always @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_FLAGS_WE       <= `SBD_FLAG_RST;
         O_SIGNED_RANGE   <= `SBD_FLAG_RST;
         O_RESULT_NULL    <= `SBD_FLAG_RST;
         O_NIBBLE_BORROW  <= `SBD_FLAG_RST;
         O_BORROW_INVERSE <= `SBD_FLAG_RST;
         O_SIGNED_RESULT  <= `SBD_FLAG_RST;
         O_EXTENDED_NULL  <= `SBD_FLAG_RST;
      end else begin
         O_FLAGS_WE <= accept & sub_sel;
         if (accept & sub_sel) begin
            O_SIGNED_RANGE   <= f_range;
            O_RESULT_NULL    <= f_null;
            O_NIBBLE_BORROW  <= f_nibble;
            O_BORROW_INVERSE <= f_borrow;
            O_SIGNED_RESULT  <= f_sign;
            O_EXTENDED_NULL  <= f_ext;
         end
      end
   end

endmodule // subtract_borrow_decrement_skip
`default_nettype wire

// ---- sim/sbd_data_memory.sv ----
// Purpose: data memory seen by the datapath
// Assumes: writes land on the rising edge
// Notes:   read is combinational on the address
`timescale 1ns/1ps
`default_nettype none
module sbd_data_memory (
   input  wire logic       clk, we,
   input  wire logic [7:0] waddr, wdata, raddr,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:255];
   assign rdata = mem[raddr];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule // sbd_data_memory
`default_nettype wire

// ---- sim/sbd_checker_monitor.sv ----
// Purpose: port checker for the datapath
// Assumes: one clock, synchronous reset
// Notes:   bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sbd_monitor #(parameter W = 8) (
   input wire logic         I_CLOCK, I_SYS_RST, I_OP_VALID, I_OP_SEL, I_BORROW_INVERSE,
   input wire logic [W-1:0] I_MEM_RDATA, I_WORKING_REGISTER, O_MEM_WDATA,
   input wire logic         O_BUSY, O_DONE, O_MEM_WE, O_FLAGS_WE, O_BORROW_INVERSE,
   input wire logic         O_SKIP_NEXT, O_DUMMY_CYCLE
);
   wire sub = I_OP_VALID && !O_BUSY && !I_OP_SEL;
   wire dec = I_OP_VALID && !O_BUSY && I_OP_SEL;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   a_sub_result: assert property (sub |=> O_MEM_WE && O_FLAGS_WE &&
      O_MEM_WDATA == $past(I_WORKING_REGISTER) - $past(I_MEM_RDATA) - W'(!$past(I_BORROW_INVERSE)))
      else $error("subtract result wrong");
   a_borrow_flag: assert property (sub |=> O_BORROW_INVERSE ==
      ({1'b0, $past(I_WORKING_REGISTER)} >= {1'b0, $past(I_MEM_RDATA)} + !$past(I_BORROW_INVERSE)))
      else $error("borrow flag wrong");
   a_dec_write: assert property (dec |=> O_MEM_WE && !O_FLAGS_WE &&
      O_MEM_WDATA == W'($past(I_MEM_RDATA) - 1'b1)) else $error("decrement write wrong");
   a_skip_zero: assert property (dec && I_MEM_RDATA == 1 |=> !O_SKIP_NEXT ##1
      O_SKIP_NEXT && O_DUMMY_CYCLE && O_DONE) else $error("skip missing");
   a_no_skip: assert property (dec && I_MEM_RDATA != 1 |=> O_DONE ##1
      !O_SKIP_NEXT && !O_DUMMY_CYCLE) else $error("unexpected skip");
   a_sub_done: assert property (sub |=> O_DONE && O_BUSY ##1 !O_BUSY)
      else $error("subtract timing wrong");
   a_busy_refuse: assert property (O_BUSY |=> !O_MEM_WE)
      else $error("write while busy");
   a_we_order: assert property (O_SKIP_NEXT |-> $past(O_MEM_WE))
      else $error("skip before write");
endmodule // sbd_monitor
bind subtract_borrow_decrement_skip sbd_monitor #(.W(W)) mon (.I_CLOCK, .I_SYS_RST,
   .I_OP_VALID, .I_OP_SEL, .I_BORROW_INVERSE, .I_MEM_RDATA, .I_WORKING_REGISTER,
   .O_MEM_WDATA, .O_BUSY, .O_DONE, .O_MEM_WE, .O_FLAGS_WE, .O_BORROW_INVERSE,
   .O_SKIP_NEXT, .O_DUMMY_CYCLE);
`default_nettype wire

// ---- sim/subtract_borrow_decrement_skip_tb_top.sv ----
// Purpose: self-checking bench for the datapath
// Assumes: memory model answers reads at once
// Notes:   subtract table, then reset check, then decrement table
`timescale 1ns/1ps
`default_nettype none
module subtract_borrow_decrement_skip_tb_top;
   logic       clk = 0, rst = 1, vld = 0, sel = 0, bi = 0, ez = 1, sk, dm;
   logic [7:0] addr = 0, acc = 0, rdat, wa, wd;
   logic       busy, done, we, fwe, ov, zf, nb, bo, sr, ezo, skip, dum;
   int         miscompares = 0, compares = 0, cyc = 0, n;
   always #2.5 clk = ~clk;
   subtract_borrow_decrement_skip dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_OP_VALID(vld),
      .I_OP_SEL(sel), .I_ADDR(addr), .I_MEM_RDATA(rdat), .I_WORKING_REGISTER(acc),
      .I_BORROW_INVERSE(bi), .I_EXTENDED_NULL(ez), .O_BUSY(busy), .O_DONE(done),
      .O_MEM_WE(we), .O_MEM_WADDR(wa), .O_MEM_WDATA(wd), .O_FLAGS_WE(fwe),
      .O_SIGNED_RANGE(ov), .O_RESULT_NULL(zf), .O_NIBBLE_BORROW(nb), .O_BORROW_INVERSE(bo),
      .O_SIGNED_RESULT(sr), .O_EXTENDED_NULL(ezo), .O_SKIP_NEXT(skip), .O_DUMMY_CYCLE(dum));
   sbd_data_memory mem (.clk(clk), .we(we), .waddr(wa), .wdata(wd), .raddr(addr),
      .rdata(rdat));
   task check(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         report_and_stop;
      end
   end
   task op(input logic s, input logic [7:0] a, w, input logic b);
      @(posedge clk); #1;
      vld = 1; sel = s; addr = a; acc = w; bi = b;
      @(posedge clk); #1;
      vld = 0; n = 0;
      while (done !== 1'b1 && n < 4) begin
         @(posedge clk); #1; n++;
      end
      sk = skip; dm = dum;
      @(posedge clk); #1;
   endtask
   task sub_cases;
      logic [17:0] t [6];
      logic [8:0]  r;
      int          s;
      t = '{{8'h05, 8'h03, 1'h1, 1'h1}, {8'h03, 8'h05, 1'h1, 1'h0},
            {8'h05, 8'h05, 1'h0, 1'h1}, {8'h05, 8'h04, 1'h0, 1'h1},
            {8'h07, 8'h07, 1'h1, 1'h0}, {8'h80, 8'h01, 1'h1, 1'h0}};
      for (int i = 0; i < 6; i++) begin
         mem.mem[8'h10] = t[i][9:2];
         ez = t[i][0];
         r = {1'b0, t[i][17:10]} - t[i][9:2] - !t[i][1];
         s = $signed(t[i][17:10]) - $signed(t[i][9:2]) - int'(!t[i][1]);
         op(1'h0, 8'h10, t[i][17:10], t[i][1]);
         check(mem.mem[8'h10], r[7:0]);
         check(bo, !r[8]);
         check(zf, r[7:0] == 8'h00);
         check(ezo, r[7:0] == 8'h00 && t[i][0]);
         check(ov, s < -128 || s > 127);
         check(sr, s < 0);
         check(nb, {1'b0, t[i][13:10]} >= {1'b0, t[i][5:2]} + !t[i][1]);
         check(sk, 1'h0);
      end
   endtask
   task reset_case;
      @(posedge clk); #1;
      rst = 1;
      repeat (2) @(posedge clk);
      #1 rst = 0;
      check(bo, 8'h00);
      check(ov, 8'h00);
      check({busy, done, we, skip}, 8'h00);
   endtask
   task dec_cases;
      logic [7:0] v [3];
      v = '{8'h01, 8'h00, 8'h80};
      for (int i = 0; i < 3; i++) begin
         mem.mem[8'h20] = v[i];
         op(1'h1, 8'h20, 8'h00, 1'h0);
         check(mem.mem[8'h20], v[i] - 8'h01);
         check(sk, v[i] == 8'h01);
         check(dm, v[i] == 8'h01);
         check(n, (v[i] == 8'h01) ? 8'h01 : 8'h00);
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 0;
      sub_cases;
      reset_case;
      dec_cases;
      report_and_stop;
   end
endmodule // subtract_borrow_decrement_skip_tb_top
`default_nettype wire
